//--- core/af_combine.sv
// Combines peripheral outputs that share each pin
`timescale 1ns/100ps
module af_combine #(
  parameter int WIDTH = 8,
  parameter int SOURCES = 2
) (
  // Peripheral outputs, one slice per source
  input wire logic [SOURCES*WIDTH-1:0] periph_out,
  input wire logic [SOURCES*WIDTH-1:0] periph_out_en,
  // Combined value per pin
  output logic [WIDTH-1:0] combined
);
  // Elaboration check: with no source there is nothing to combine
  if (SOURCES < 1) begin : g_source_check
    $error("af_combine needs at least one source");
  end
  // Disabled sources read as 1 so they never pull the AND low
  always_comb begin
    combined = '1;
    for (int s = 0; s < SOURCES; s++) begin
      combined = combined & (periph_out[s*WIDTH +: WIDTH] | ~periph_out_en[s*WIDTH +: WIDTH]);
    end
  end
endmodule

//--- core/pin_sync.sv
// Two-flop synchroniser for the pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

//--- core/port_pin_config_af_mux.sv
// Port pin configuration, latches and alternate-function multiplexing
// What this block does
// - Pin n takes its three-bit code from bit n of each config register.
// - Codes 000,100 bidir; 010,110 output; 001,101 input CMOS/TTL.
// - 011 alternate push-pull, 111 alternate open-drain or analog on converter pins.
// - Output mode drives pin; instruction end copies master into input and slave latches.
// - Bidir samples pin at instruction start, master to slave at instruction end.
// - Bidir driver is open-drain or weak pull-up; pull-up absent where disabled.
// - Reading a bidirectional pin returns the pin level, not the latch.
// - Alternate output bypasses the slave latch; peripheral value drives the pad directly.
// - Alternate output mode still samples the pin at instruction start.
// - Unconnected alternate output: push-pull drives high, open-drain floats.
// - Pin input feeds all peripheral inputs when the pin is not driven; port reads still work.
// - Converter pin with code 111 forces alternate output 1, passes analog.
// - Several peripheral outputs on one pin are ANDed.
// - Driven output value always appears on the peripheral input.
// - In wait-for-interrupt pins keep state and configuration.
// - In halt pins keep state; nothing here reacts to halt.
// - Reset gives bidirectional weak pull-up and data register all ones.
// - Input mode tristates driver, samples at start, master to slave at end.
// - Data write loads master latch; data read returns input latch.
`timescale 1ns/100ps
module port_pin_config_af_mux #(
  parameter int WIDTH = 8,
  parameter int AF_SOURCES = 2,
  parameter logic [7:0] PULLUP_PRESENT = 8'hFF,
  parameter logic [7:0] ANALOG_PINS = 8'h00
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register-file bus
  input wire logic [port_pkg::REG_ADDR_WIDTH-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Instruction strobes from the core
  input wire logic instr_start,
  input wire logic instr_end,
  // Pin
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup_en,
  output logic [7:0] pin_ttl_sel,
  output logic [7:0] analog_sel,
  // Peripherals
  input wire logic [AF_SOURCES*8-1:0] periph_out,
  input wire logic [AF_SOURCES*8-1:0] periph_out_en,
  output logic [7:0] periph_in
);
  import port_pkg::*;

  // Elaboration checks: the latch and pad logic is laid out for one 8-bit port
  if (WIDTH != PORT_WIDTH) begin : g_width_check
    $error("port width must be 8");
  end
  if (AF_SOURCES < 1) begin : g_source_check
    $error("need at least one peripheral source");
  end

  logic [7:0] port_config_high;
  logic [7:0] port_config_mid;
  logic [7:0] port_config_low;
  logic [7:0] port_output_data;
  logic [7:0] input_latch;
  logic [7:0] slave_latch;
  logic [7:0] next_config_high;
  logic [7:0] next_config_mid;
  logic [7:0] next_config_low;
  logic [7:0] next_output_data;
  logic [7:0] next_input_latch;
  logic [7:0] next_slave_latch;
  logic [7:0] next_rdata;
  logic [7:0] next_pin_out;
  logic [7:0] next_pin_oe;
  logic [7:0] next_pullup;
  logic [7:0] next_ttl;
  logic [7:0] next_analog;
  logic [7:0] next_periph_in;
  logic [7:0] pin_sampled;
  logic [7:0] af_value;

  pin_sync #(
    .WIDTH(8)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(pin_in),
    .sync_out(pin_sampled)
  );

  af_combine #(
    .WIDTH(8),
    .SOURCES(AF_SOURCES)
  ) u_af (
    .periph_out(periph_out),
    .periph_out_en(periph_out_en),
    .combined(af_value)
  );

  // Code of pin n from bit n of each register
  function automatic pin_code_e pin_code(input logic [7:0] hi, input logic [7:0] mid, input logic [7:0] lo,
                                         input int n);
    pin_code = pin_code_e'({hi[n], mid[n], lo[n]});
  endfunction

  function automatic pin_class_e pin_class(input pin_code_e code);
    case (code)
      CODE_BID_WPU, CODE_BID_OD: pin_class = CLASS_BID;
      CODE_OUT_PP, CODE_OUT_OD: pin_class = CLASS_OUT;
      CODE_IN_CMOS, CODE_IN_TTL: pin_class = CLASS_IN;
      default: pin_class = CLASS_AF;
    endcase
  endfunction

  // Register file: writes and reads
  always_comb begin
    next_config_high = port_config_high;
    next_config_mid = port_config_mid;
    next_config_low = port_config_low;
    next_output_data = port_output_data;
    next_rdata = reg_rdata;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_DATA: next_output_data = reg_wdata;
        ADDR_CFG_LOW: next_config_low = reg_wdata;
        ADDR_CFG_MID: next_config_mid = reg_wdata;
        ADDR_CFG_HIGH: next_config_high = reg_wdata;
        default: next_output_data = port_output_data;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_DATA: next_rdata = input_latch;
        ADDR_CFG_LOW: next_rdata = port_config_low;
        ADDR_CFG_MID: next_rdata = port_config_mid;
        ADDR_CFG_HIGH: next_rdata = port_config_high;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_config_high <= CFG_RESET;
      port_config_mid <= CFG_RESET;
      port_config_low <= CFG_RESET;
      port_output_data <= DATA_RESET;
      reg_rdata <= 8'h00;
    end else begin
      port_config_high <= next_config_high;
      port_config_mid <= next_config_mid;
      port_config_low <= next_config_low;
      port_output_data <= next_output_data;
      reg_rdata <= next_rdata;
    end
  end

  // Latches and pin drive; no low-power input, so wait and halt leave all as is
  always_comb begin
    pin_code_e code;
    pin_class_e cls;
    logic od;
    code = CODE_BID_WPU;
    cls = CLASS_BID;
    od = 1'b0;
    next_input_latch = input_latch;
    next_slave_latch = slave_latch;
    next_pin_out = 8'h00;
    next_pin_oe = 8'h00;
    next_pullup = 8'h00;
    next_ttl = 8'h00;
    next_analog = 8'h00;
    next_periph_in = 8'h00;
    for (int n = 0; n < 8; n++) begin
      code = pin_code(port_config_high, port_config_mid, port_config_low, n);
      cls = pin_class(code);
      od = code[2];
      next_ttl[n] = (code != CODE_IN_CMOS);
      // Sampling at start, master-to-slave at end
      if (instr_start && cls != CLASS_OUT) begin
        next_input_latch[n] = pin_sampled[n];
      end
      if (instr_end && cls != CLASS_AF) begin
        next_slave_latch[n] = port_output_data[n];
        if (cls == CLASS_OUT) begin
          next_input_latch[n] = port_output_data[n];
        end
      end
      case (cls)
        CLASS_OUT: begin
          next_pin_out[n] = slave_latch[n];
          next_pin_oe[n] = od ? ~slave_latch[n] : 1'b1;
        end
        CLASS_BID: begin
          // Open-drain sink; a one is held only by the weak pull-up
          next_pin_out[n] = 1'b0;
          next_pin_oe[n] = ~slave_latch[n];
          next_pullup[n] = ~od & PULLUP_PRESENT[n] & slave_latch[n];
        end
        CLASS_AF: begin
          if (ANALOG_PINS[n] && code == CODE_AF_OD) begin
            next_analog[n] = 1'b1;
          end else begin
            // Peripheral value goes straight to the pad
            next_pin_out[n] = od ? 1'b0 : af_value[n];
            next_pin_oe[n] = od ? ~af_value[n] : 1'b1;
          end
        end
        default: next_pin_oe[n] = 1'b0;
      endcase
      // Peripheral sees the driven level when driving, else the pin
      next_periph_in[n] = next_pin_oe[n] ? next_pin_out[n] : pin_sampled[n];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      input_latch <= DATA_RESET;
      slave_latch <= DATA_RESET;
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      // Pull-ups hold the pads high while reset is held, not only after it
      pin_pullup_en <= PULLUP_PRESENT;
      pin_ttl_sel <= 8'h00;
      analog_sel <= 8'h00;
      periph_in <= 8'h00;
    end else begin
      input_latch <= next_input_latch;
      slave_latch <= next_slave_latch;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pin_pullup_en <= next_pullup;
      pin_ttl_sel <= next_ttl;
      analog_sel <= next_analog;
      periph_in <= next_periph_in;
    end
  end

  // Assertions
  sequence data_write_s;
    reg_wr && reg_addr == ADDR_DATA;
  endsequence

  data_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    data_write_s |=> port_output_data == $past(reg_wdata))
    else $error("data write not stored");

  cfg_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_CFG_LOW |=> port_config_low == $past(reg_wdata))
    else $error("config write not stored");

  data_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_DATA |=> reg_rdata == $past(input_latch))
    else $error("data read wrong");

  out_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    instr_end && !port_config_low[0] && port_config_mid[0] |=> input_latch[0] == $past(port_output_data[0])
      && slave_latch[0] == $past(port_output_data[0]))
    else $error("output copy missing");

  bid_sample_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    instr_start && !instr_end && ({port_config_mid[0], port_config_low[0]} == 2'b00) |=>
      input_latch[0] == $past(pin_sampled[0]))
    else $error("bidir sample missing");

  input_tristate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    port_config_low[1] && !port_config_mid[1] |=> !pin_oe[1])
    else $error("input not tristated");

  af_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    {port_config_high[2], port_config_mid[2], port_config_low[2]} == CODE_AF_PP |=>
      pin_oe[2] && pin_out[2] == $past(af_value[2]))
    else $error("alternate output not driven");

  periph_loop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pin_oe[3] |-> periph_in[3] == pin_out[3])
    else $error("driven value not on peripheral input");

  // Pin codes watched by the checks below
  sequence pin4_out_pp_s;
    {port_config_high[4], port_config_mid[4], port_config_low[4]} == CODE_OUT_PP;
  endsequence

  sequence pin4_cmos_s;
    {port_config_high[4], port_config_mid[4], port_config_low[4]} == CODE_IN_CMOS;
  endsequence

  sequence pin6_wpu_s;
    {port_config_high[6], port_config_mid[6], port_config_low[6]} == CODE_BID_WPU;
  endsequence

  sequence pin7_analog_s;
    ANALOG_PINS[7] && {port_config_high[7], port_config_mid[7], port_config_low[7]} == CODE_AF_OD;
  endsequence

  out_pp_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pin4_out_pp_s |=> pin_oe[4] && pin_out[4] == $past(slave_latch[4]))
    else $error("push-pull output not driven from slave latch");

  out_od_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    {port_config_high[5], port_config_mid[5], port_config_low[5]} == CODE_OUT_OD |=>
      !pin_out[5] && pin_oe[5] == !$past(slave_latch[5]))
    else $error("open-drain output wrong");

  bid_pullup_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pin6_wpu_s |=> !pin_out[6] && pin_oe[6] == !$past(slave_latch[6])
      && pin_pullup_en[6] == (PULLUP_PRESENT[6] && $past(slave_latch[6])))
    else $error("weak pull-up drive wrong");

  bid_od_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    {port_config_high[6], port_config_mid[6], port_config_low[6]} == CODE_BID_OD |=> !pin_pullup_en[6])
    else $error("pull-up on open-drain pin");

  end_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    instr_end && !(port_config_mid[1] && port_config_low[1]) |=>
      slave_latch[1] == $past(port_output_data[1]))
    else $error("master not copied to slave");

  af_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    instr_end && port_config_mid[1] && port_config_low[1] |=> $stable(slave_latch[1]))
    else $error("alternate pin slave latch moved at instruction end");

  af_sample_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    instr_start && port_config_mid[2] && port_config_low[2] |=> input_latch[2] == $past(pin_sampled[2]))
    else $error("alternate pin not sampled");

  in_sample_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    instr_start && port_config_low[1] && !port_config_mid[1] |=> input_latch[1] == $past(pin_sampled[1]))
    else $error("input pin not sampled");

  af_od_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ANALOG_PINS[2] && {port_config_high[2], port_config_mid[2], port_config_low[2]} == CODE_AF_OD |=>
      !pin_out[2] && pin_oe[2] == !$past(af_value[2]))
    else $error("alternate open-drain drive wrong");

  analog_route_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pin7_analog_s |=> analog_sel[7] && !pin_oe[7])
    else $error("analog pin not routed");

  analog_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(ANALOG_PINS[7] && {port_config_high[7], port_config_mid[7], port_config_low[7]} == CODE_AF_OD) |=>
      !analog_sel[7])
    else $error("analog route left on");

  ttl_cmos_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pin4_cmos_s |=> !pin_ttl_sel[4])
    else $error("CMOS input level not selected");

  periph_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !pin_oe[3] |-> periph_in[3] == $past(pin_sampled[3]))
    else $error("pin level not on peripheral input");
endmodule

//--- core/port_pkg.sv
// Package: constants and types for the 8-bit port configuration block
package port_pkg;
  localparam int PORT_WIDTH = 8;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'hFF;
  localparam int REG_ADDR_WIDTH = 2;
  localparam logic [1:0] ADDR_DATA = 2'h0;
  localparam logic [1:0] ADDR_CFG_LOW = 2'h1;
  localparam logic [1:0] ADDR_CFG_MID = 2'h2;
  localparam logic [1:0] ADDR_CFG_HIGH = 2'h3;
  localparam int SYNC_STAGES = 2;
  // Pin codes written high, mid, low
  typedef enum logic [2:0] {
    CODE_BID_WPU = 3'b000,
    CODE_BID_OD = 3'b100,
    CODE_OUT_PP = 3'b010,
    CODE_OUT_OD = 3'b110,
    CODE_IN_CMOS = 3'b001,
    CODE_IN_TTL = 3'b101,
    CODE_AF_PP = 3'b011,
    CODE_AF_OD = 3'b111
  } pin_code_e;
  typedef enum logic [1:0] {
    CLASS_BID = 2'b00,
    CLASS_OUT = 2'b01,
    CLASS_IN = 2'b10,
    CLASS_AF = 2'b11
  } pin_class_e;
endpackage

//--- tb/port_far_side.sv
// Far-side model: pad resolution and peripheral output sources
`timescale 1ns/100ps
module port_far_side (
  // Clock
  input wire logic sys_clk,
  // Pad side of the block
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  output logic [7:0] pin_in,
  // External drivers set by the bench
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // Peripheral sources set by the bench
  input wire logic [15:0] src_val,
  input wire logic [15:0] src_en,
  output logic [15:0] periph_out,
  output logic [15:0] periph_out_en
);
  logic [7:0] float_pat = 8'h55;
  // Undriven pads toggle so a missing drive never reads steady
  always @(posedge sys_clk) float_pat <= ~float_pat;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i] || ext_en[i]) begin
        pin_in[i] = (pin_oe[i] ? pin_out[i] : 1'b1) & (ext_en[i] ? ext_val[i] : 1'b1);
      end else if (pin_pullup_en[i]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = float_pat[i];
      end
    end
  end
  // Detached sources show garbage; the block must ignore them
  assign periph_out = src_val ^ ~src_en;
  assign periph_out_en = src_en;
endmodule

//--- tb/port_pin_config_af_mux_tb.sv
// Self-checking bench for the port pin configuration block
`timescale 1ns/100ps
module port_pin_config_af_mux_tb;
  import port_pkg::*;
  logic sys_clk, rst_n, reg_wr, reg_rd, instr_start, instr_end;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, pin_pullup_en, pin_ttl_sel, analog_sel, periph_in;
  logic [7:0] ext_val, ext_en, rv;
  logic [15:0] src_val, src_en, periph_out, periph_out_en;
  int error_cnt = 0;
  int n_tests = 0;
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  port_pin_config_af_mux #(.PULLUP_PRESENT(8'h7F), .ANALOG_PINS(8'h80)) port_pin_config_af_mux_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .instr_start(instr_start), .instr_end(instr_end),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .pin_ttl_sel(pin_ttl_sel), .analog_sel(analog_sel), .periph_out(periph_out),
    .periph_out_en(periph_out_en), .periph_in(periph_in));
  port_far_side port_far_side_inst (
    .sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .pin_in(pin_in), .ext_val(ext_val), .ext_en(ext_en), .src_val(src_val), .src_en(src_en),
    .periph_out(periph_out), .periph_out_en(periph_out_en));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1 chk(reg_rdata, exp, what);
  endtask
  task automatic cfg(input logic [7:0] h, input logic [7:0] m, input logic [7:0] l);
    wr(ADDR_CFG_HIGH, h);
    wr(ADDR_CFG_MID, m);
    wr(ADDR_CFG_LOW, l);
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // Strobe taken at one edge; pads follow one edge later
  task automatic strobe(input logic s, input logic e);
    @(posedge sys_clk);
    instr_start <= s;
    instr_end <= e;
    @(posedge sys_clk);
    instr_start <= 1'b0;
    instr_end <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_reset();
    chk(pin_oe, 8'h00, "reset oe");
    chk(pin_pullup_en, 8'h7F, "reset pullup");
    rd(ADDR_DATA, DATA_RESET, "reset data");
    rd(ADDR_CFG_HIGH, CFG_RESET, "reset cfg");
    wr(ADDR_CFG_LOW, 8'hA5);
    wr(ADDR_CFG_MID, 8'h5A);
    wr(ADDR_CFG_HIGH, 8'h3C);
    rd(ADDR_CFG_LOW, 8'hA5, "cfg low");
    rd(ADDR_CFG_MID, 8'h5A, "cfg mid");
    rd(ADDR_CFG_HIGH, 8'h3C, "cfg high");
  endtask
  task automatic t_output();
    cfg(8'h00, 8'hFF, 8'h00);
    wr(ADDR_DATA, 8'h96);
    strobe(1'b0, 1'b1);
    chk(pin_out, 8'h96, "pp out");
    chk(pin_oe, 8'hFF, "pp oe");
    chk(periph_in, 8'h96, "pp periph");
    rd(ADDR_DATA, 8'h96, "out latch");
    cfg(8'hFF, 8'hFF, 8'h00);
    strobe(1'b0, 1'b1);
    chk(pin_oe, 8'h69, "od oe");
  endtask
  task automatic t_bidir();
    cfg(8'hFF, 8'h00, 8'h00);
    ext_val <= 8'h03;
    ext_en <= 8'h0F;
    wr(ADDR_DATA, 8'h0F);
    strobe(1'b0, 1'b1);
    chk(pin_oe, 8'hF0, "bid oe");
    strobe(1'b1, 1'b0);
    rd(ADDR_DATA, 8'h03, "bid pin read");
    cfg(8'h00, 8'h00, 8'h00);
    chk(pin_pullup_en, 8'h0F, "bid pullup");
  endtask
  task automatic t_input();
    cfg(8'h0F, 8'h00, 8'hFF);
    chk(pin_oe, 8'h00, "in oe");
    chk(pin_ttl_sel, 8'h0F, "in ttl");
    ext_val <= 8'hA5;
    ext_en <= 8'hFF;
    repeat (4) @(posedge sys_clk);
    strobe(1'b1, 1'b0);
    rd(ADDR_DATA, 8'hA5, "in read");
    chk(periph_in, 8'hA5, "in periph");
  endtask
  task automatic t_af();
    ext_en <= 8'h00;
    src_val <= {8'h02, 8'h0C};
    src_en <= {8'h06, 8'h0F};
    cfg(8'h00, 8'hFF, 8'hFF);
    chk(pin_out, 8'hF8, "af and");
    chk(pin_oe, 8'hFF, "af pp oe");
    chk(periph_in, 8'hF8, "af periph");
    cfg(8'hFF, 8'hFF, 8'hFF);
    chk(analog_sel, 8'h80, "analog");
    chk(pin_oe, 8'h07, "af od oe");
    ext_val <= 8'hD8;
    ext_en <= 8'hF8;
    repeat (4) @(posedge sys_clk);
    strobe(1'b1, 1'b1);
    rd(ADDR_DATA, 8'hD8, "af sample");
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #(50 * 4000);
    error_cnt++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, instr_start, instr_end} = 4'h0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    ext_val = 8'h00;
    ext_en = 8'h00;
    src_val = 16'h0000;
    src_en = 16'h0000;
    repeat (15) @(posedge sys_clk);
    #1 chk(pin_pullup_en, 8'h7F, "pullup in reset");
    chk(pin_oe, 8'h00, "oe in reset");
    @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    t_reset();
    t_output();
    t_bidir();
    t_input();
    t_af();
    end_sim();
  end
endmodule
